// ===== hw/bstap_pkg.sv
// Package of constants and types for the boundary-scan test access port controller
package bstap_pkg;

    // ------------------------------------------------------------------
    // Register lengths
    // ------------------------------------------------------------------
    localparam int IR_WIDTH = 8;
    localparam int BOUNDARY_WIDTH = 36;
    localparam int CONTROL_WIDTH = 11;

    // ------------------------------------------------------------------
    // Reset and capture values
    // ------------------------------------------------------------------
    localparam logic [IR_WIDTH-1:0] IR_RESET_VALUE = 8'hFF;
    localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VALUE = 8'h81;
    localparam logic [BOUNDARY_WIDTH-1:0] BOUNDARY_RESET_VALUE = 36'h0_0000_0000;
    localparam logic [CONTROL_WIDTH-1:0] CONTROL_RESET_VALUE = 11'h002;
    localparam logic BYPASS_CAPTURE_VALUE = 1'b0;

    // ------------------------------------------------------------------
    // Instruction codes that select a data register
    // ------------------------------------------------------------------
    localparam logic [IR_WIDTH-1:0] OPC_BOUNDARY = 8'h00;
    localparam logic [IR_WIDTH-1:0] OPC_CONTROL = 8'h0A;
    localparam logic [IR_WIDTH-1:0] OPC_RUN_TEST = 8'h09;

    // ------------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_TEST_LOGIC_RESET = 4'h0,
        ST_RUN_TEST_IDLE = 4'h1,
        ST_SELECT_DR = 4'h2,
        ST_CAPTURE_DR = 4'h3,
        ST_SHIFT_DR = 4'h4,
        ST_EXIT1_DR = 4'h5,
        ST_PAUSE_DR = 4'h6,
        ST_EXIT2_DR = 4'h7,
        ST_UPDATE_DR = 4'h8,
        ST_SELECT_IR = 4'h9,
        ST_CAPTURE_IR = 4'hA,
        ST_SHIFT_IR = 4'hB,
        ST_EXIT1_IR = 4'hC,
        ST_PAUSE_IR = 4'hD,
        ST_EXIT2_IR = 4'hE,
        ST_UPDATE_IR = 4'hF
    } bstap_state_t;

    // ------------------------------------------------------------------
    // Pin sampling chain and module state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bstap_pins_t;

    typedef struct packed {
        bstap_pins_t meta;
        bstap_pins_t sync;
        logic tck_prev;
        bstap_state_t tap;
        logic [IR_WIDTH-1:0] ir_shift;
        logic [IR_WIDTH-1:0] ir_current;
        logic [BOUNDARY_WIDTH-1:0] boundary_shift;
        logic [BOUNDARY_WIDTH-1:0] boundary_latch;
        logic [CONTROL_WIDTH-1:0] control_shift;
        logic [CONTROL_WIDTH-1:0] control_latch;
        logic bypass;
        logic tdo;
        logic tdo_oe;
        logic test_mode;
        logic op_run;
    } bstap_regs_t;

    localparam bstap_regs_t REGS_RESET = '{
        meta: '{tck: 1'b0, tms: 1'b1, tdi: 1'b1},
        sync: '{tck: 1'b0, tms: 1'b1, tdi: 1'b1},
        tck_prev: 1'b0,
        tap: ST_TEST_LOGIC_RESET,
        ir_shift: IR_RESET_VALUE,
        ir_current: IR_RESET_VALUE,
        boundary_shift: BOUNDARY_RESET_VALUE,
        boundary_latch: BOUNDARY_RESET_VALUE,
        control_shift: CONTROL_RESET_VALUE,
        control_latch: CONTROL_RESET_VALUE,
        bypass: BYPASS_CAPTURE_VALUE,
        tdo: 1'b0,
        tdo_oe: 1'b0,
        test_mode: 1'b0,
        op_run: 1'b0
    };

endpackage

// ===== hw/bstap_controller.sv
// Boundary-scan test access port controller with instruction and data registers
//
// Summary of operation
// - Sample on rising TCK, drive on falling
// - IR 8, boundary 36, control 11, bypass 1
// - Shift stage plus shadow latch, bypass none
// - Sixteen states advancing on rising TCK
// - Six stable states, ten single-cycle states
// - Power-up in reset state, test logic off
// - TMS high reaches reset within five cycles
// - Reset state loads instruction all ones
// - Reset clears every boundary bit
// - Reset loads control register with bit 1
// - Control operation runs only in Run-Test/Idle
// - Select states do nothing, leave next cycle
// - Capture-DR loads boundary or bypass register leaving state
// - TDO driven from first falling edge, LSB
// - One shift per rising edge, TDI toward TDO
// - TDO released on falling edge in Exit1
// - Return to shift keeps contents, no capture
// - Pause states hold partial contents indefinitely
// - Update-DR loads shadow on falling edge
// - Capture-IR loads fixed status pattern
// - Update-IR makes new instruction current
// - Bypass captures zero in Capture-DR
// - Control register unchanged in Capture-DR
`timescale 1ns/10ps
`default_nettype none

module bstap_controller (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic [bstap_pkg::BOUNDARY_WIDTH-1:0] i_boundary_capture,
    output logic o_tdo,
    output logic o_tdo_oe,
    output logic o_test_mode,
    output logic o_op_run,
    output logic [bstap_pkg::CONTROL_WIDTH-1:0] o_control,
    output logic [bstap_pkg::BOUNDARY_WIDTH-1:0] o_boundary,
    output logic [bstap_pkg::IR_WIDTH-1:0] o_instruction,
    output logic [3:0] o_tap_state
);

    // ------------------------------------------------------------------
    // State graph
    // ------------------------------------------------------------------
    function automatic bstap_pkg::bstap_state_t tap_step(
        input bstap_pkg::bstap_state_t cur,
        input logic tms
    );
        bstap_pkg::bstap_state_t nx;
        nx = bstap_pkg::ST_TEST_LOGIC_RESET;
        case (cur)
            bstap_pkg::ST_TEST_LOGIC_RESET: begin
                nx = tms ? bstap_pkg::ST_TEST_LOGIC_RESET : bstap_pkg::ST_RUN_TEST_IDLE;
            end
            bstap_pkg::ST_RUN_TEST_IDLE: begin
                nx = tms ? bstap_pkg::ST_SELECT_DR : bstap_pkg::ST_RUN_TEST_IDLE;
            end
            bstap_pkg::ST_SELECT_DR: begin
                nx = tms ? bstap_pkg::ST_SELECT_IR : bstap_pkg::ST_CAPTURE_DR;
            end
            bstap_pkg::ST_CAPTURE_DR: begin
                nx = tms ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
            end
            bstap_pkg::ST_SHIFT_DR: begin
                nx = tms ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
            end
            bstap_pkg::ST_EXIT1_DR: begin
                nx = tms ? bstap_pkg::ST_UPDATE_DR : bstap_pkg::ST_PAUSE_DR;
            end
            bstap_pkg::ST_PAUSE_DR: begin
                nx = tms ? bstap_pkg::ST_EXIT2_DR : bstap_pkg::ST_PAUSE_DR;
            end
            bstap_pkg::ST_EXIT2_DR: begin
                nx = tms ? bstap_pkg::ST_UPDATE_DR : bstap_pkg::ST_SHIFT_DR;
            end
            bstap_pkg::ST_UPDATE_DR: begin
                nx = tms ? bstap_pkg::ST_SELECT_DR : bstap_pkg::ST_RUN_TEST_IDLE;
            end
            bstap_pkg::ST_SELECT_IR: begin
                nx = tms ? bstap_pkg::ST_TEST_LOGIC_RESET : bstap_pkg::ST_CAPTURE_IR;
            end
            bstap_pkg::ST_CAPTURE_IR: begin
                nx = tms ? bstap_pkg::ST_EXIT1_IR : bstap_pkg::ST_SHIFT_IR;
            end
            bstap_pkg::ST_SHIFT_IR: begin
                nx = tms ? bstap_pkg::ST_EXIT1_IR : bstap_pkg::ST_SHIFT_IR;
            end
            bstap_pkg::ST_EXIT1_IR: begin
                nx = tms ? bstap_pkg::ST_UPDATE_IR : bstap_pkg::ST_PAUSE_IR;
            end
            bstap_pkg::ST_PAUSE_IR: begin
                nx = tms ? bstap_pkg::ST_EXIT2_IR : bstap_pkg::ST_PAUSE_IR;
            end
            bstap_pkg::ST_EXIT2_IR: begin
                nx = tms ? bstap_pkg::ST_UPDATE_IR : bstap_pkg::ST_SHIFT_IR;
            end
            bstap_pkg::ST_UPDATE_IR: begin
                nx = tms ? bstap_pkg::ST_SELECT_DR : bstap_pkg::ST_RUN_TEST_IDLE;
            end
            default: begin
                nx = bstap_pkg::ST_TEST_LOGIC_RESET;
            end
        endcase
        return nx;
    endfunction

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    bstap_pkg::bstap_regs_t regs_reg;
    bstap_pkg::bstap_regs_t regs_next;

    logic tck_rise;
    logic tck_fall;
    logic sel_boundary;
    logic sel_control;
    logic in_shift;
    logic dr_lsb;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        regs_next = regs_reg;

        // Two-stage synchroniser; only the second stage is read below
        regs_next.meta.tck = i_tck;
        regs_next.meta.tms = i_tms;
        regs_next.meta.tdi = i_tdi;
        regs_next.sync = regs_reg.meta;
        regs_next.tck_prev = regs_reg.sync.tck;

        tck_rise = regs_reg.sync.tck & ~regs_reg.tck_prev;
        tck_fall = ~regs_reg.sync.tck & regs_reg.tck_prev;

        sel_boundary = (regs_reg.ir_current == bstap_pkg::OPC_BOUNDARY);
        sel_control = (regs_reg.ir_current == bstap_pkg::OPC_CONTROL);
        in_shift = (regs_reg.tap == bstap_pkg::ST_SHIFT_DR) ||
                   (regs_reg.tap == bstap_pkg::ST_SHIFT_IR);

        if (sel_boundary) begin
            dr_lsb = regs_reg.boundary_shift[0];
        end else if (sel_control) begin
            dr_lsb = regs_reg.control_shift[0];
        end else begin
            dr_lsb = regs_reg.bypass;
        end

        // Rising edge: capture and shift, then advance
        if (tck_rise) begin
            case (regs_reg.tap)
                bstap_pkg::ST_CAPTURE_DR: begin
                    if (sel_boundary) begin
                        regs_next.boundary_shift = i_boundary_capture;
                    end else if (!sel_control) begin
                        regs_next.bypass = bstap_pkg::BYPASS_CAPTURE_VALUE;
                    end
                    // Control register keeps its contents here
                end
                bstap_pkg::ST_SHIFT_DR: begin
                    if (sel_boundary) begin
                        regs_next.boundary_shift = {regs_reg.sync.tdi,
                            regs_reg.boundary_shift[bstap_pkg::BOUNDARY_WIDTH-1:1]};
                    end else if (sel_control) begin
                        regs_next.control_shift = {regs_reg.sync.tdi,
                            regs_reg.control_shift[bstap_pkg::CONTROL_WIDTH-1:1]};
                    end else begin
                        regs_next.bypass = regs_reg.sync.tdi;
                    end
                end
                bstap_pkg::ST_CAPTURE_IR: begin
                    regs_next.ir_shift = bstap_pkg::IR_CAPTURE_VALUE;
                end
                bstap_pkg::ST_SHIFT_IR: begin
                    regs_next.ir_shift = {regs_reg.sync.tdi,
                        regs_reg.ir_shift[bstap_pkg::IR_WIDTH-1:1]};
                end
                default: begin
                    // Other states move no data
                end
            endcase
            regs_next.tap = tap_step(regs_reg.tap, regs_reg.sync.tms);
        end

        // Falling edge: outputs and shadow updates
        if (tck_fall) begin
            regs_next.tdo_oe = in_shift;
            if (regs_reg.tap == bstap_pkg::ST_SHIFT_IR) begin
                regs_next.tdo = regs_reg.ir_shift[0];
            end else if (regs_reg.tap == bstap_pkg::ST_SHIFT_DR) begin
                regs_next.tdo = dr_lsb;
            end
            if (regs_reg.tap == bstap_pkg::ST_UPDATE_DR) begin
                if (sel_boundary) begin
                    regs_next.boundary_latch = regs_reg.boundary_shift;
                end else if (sel_control) begin
                    regs_next.control_latch = regs_reg.control_shift;
                end
            end
            if (regs_reg.tap == bstap_pkg::ST_UPDATE_IR) begin
                regs_next.ir_current = regs_reg.ir_shift;
            end
        end

        // Entering or staying in reset state holds test logic reset
        if (regs_next.tap == bstap_pkg::ST_TEST_LOGIC_RESET) begin
            regs_next.ir_shift = bstap_pkg::IR_RESET_VALUE;
            regs_next.ir_current = bstap_pkg::IR_RESET_VALUE;
            regs_next.boundary_shift = bstap_pkg::BOUNDARY_RESET_VALUE;
            regs_next.boundary_latch = bstap_pkg::BOUNDARY_RESET_VALUE;
            regs_next.control_shift = bstap_pkg::CONTROL_RESET_VALUE;
            regs_next.control_latch = bstap_pkg::CONTROL_RESET_VALUE;
        end

        // Test mode only outside reset state and with boundary instruction
        regs_next.test_mode = (regs_reg.tap != bstap_pkg::ST_TEST_LOGIC_RESET) &&
                              sel_boundary;
        regs_next.op_run = (regs_reg.tap == bstap_pkg::ST_RUN_TEST_IDLE) &&
                           (regs_reg.ir_current == bstap_pkg::OPC_RUN_TEST);

        if (i_reset) begin
            regs_next = bstap_pkg::REGS_RESET;
        end
    end

    always_ff @(posedge i_clk) begin
        regs_reg <= regs_next;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_tdo = regs_reg.tdo;
    assign o_tdo_oe = regs_reg.tdo_oe;
    assign o_test_mode = regs_reg.test_mode;
    assign o_op_run = regs_reg.op_run;
    assign o_control = regs_reg.control_latch;
    assign o_boundary = regs_reg.boundary_latch;
    assign o_instruction = regs_reg.ir_current;
    assign o_tap_state = regs_reg.tap;

endmodule

`default_nettype wire

// ===== tb/bstap_master.sv
// Scan test master model driving clock, mode select and data lines
`timescale 1ns/10ps
`default_nettype none
module bstap_master (
    input wire logic i_tdo,
    input wire logic i_tdo_oe,
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi
);
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
    end
    // One 400 ns period; clock rests low, data returns to pull-up level
    task automatic step(input logic tms, input logic tdi, output logic q);
        o_tms = tms;
        o_tdi = tdi;
        #113 o_tck = 1'b1;
        #100 q = i_tdo_oe ? i_tdo : 1'bz;
        #100 o_tck = 1'b0;
        #87 o_tdi = 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== tb/bstap_monitor.sv
// Port-level checks of the scan controller, bound into the design
`timescale 1ns/10ps
`default_nettype none
module bstap_monitor (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic [bstap_pkg::BOUNDARY_WIDTH-1:0] i_boundary_capture,
    input wire logic o_tdo,
    input wire logic o_tdo_oe,
    input wire logic o_test_mode,
    input wire logic o_op_run,
    input wire logic [bstap_pkg::CONTROL_WIDTH-1:0] o_control,
    input wire logic [bstap_pkg::BOUNDARY_WIDTH-1:0] o_boundary,
    input wire logic [bstap_pkg::IR_WIDTH-1:0] o_instruction,
    input wire logic [3:0] o_tap_state
);
    // Next state per state code, one nibble each, for mode low and high
    localparam logic [63:0] NEXT_LOW = 64'h1BDD_BBA1_4664_4311;
    localparam logic [63:0] NEXT_HIGH = 64'h2FEF_CC02_8785_5920;
    logic [2:0] tck_q;
    logic [1:0] tms_q;
    logic [2:0] ones;
    logic rise;
    logic fall;
    logic [3:0] want;
    assign rise = tck_q[1] & ~tck_q[2];
    assign fall = tck_q[2] & ~tck_q[1];
    assign want = tms_q[1] ? NEXT_HIGH[{o_tap_state, 2'b00} +: 4]
                           : NEXT_LOW[{o_tap_state, 2'b00} +: 4];
    // Mirror of the pin synchronisers; counts high mode bits in a row
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            tck_q <= 3'h0;
            tms_q <= 2'h3;
            ones <= 3'h0;
        end else begin
            tck_q <= {tck_q[1:0], i_tck};
            tms_q <= {tms_q[0], i_tms};
            if (rise)
                ones <= !tms_q[1] ? 3'h0 : (ones == 3'h5) ? ones : ones + 3'h1;
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    sequence fall_in(logic [3:0] a, logic [3:0] b);
        !$past(i_reset) && $past(fall) && $past(o_tap_state) inside {a, b};
    endsequence
    next_state_a: assert property (rise |=> o_tap_state == $past(want))
        else $error("wrong next state");
    five_ones_a: assert property (ones == 3'h5 |-> o_tap_state == 4'h0)
        else $error("no reset after five high");
    tdo_edge_a: assert property (!$past(i_reset) && $changed({o_tdo, o_tdo_oe}) |-> $past(fall))
        else $error("output moved off falling edge");
    tdo_on_a: assert property (fall_in(4'h4, 4'hB) |-> o_tdo_oe)
        else $error("output not driven in shift");
    tdo_off_a: assert property (fall_in(4'h5, 4'hC) |-> !o_tdo_oe)
        else $error("output not released in exit");
    reset_values_a: assert property (o_tap_state == 4'h0 |=> !o_test_mode
        && o_instruction == bstap_pkg::IR_RESET_VALUE && o_boundary == '0
        && o_control == bstap_pkg::CONTROL_RESET_VALUE) else $error("bad reset values");
    latch_update_a: assert property (!$past(i_reset)
        && $changed({o_instruction, o_boundary, o_control}) |-> o_tap_state == 4'h0
        || $past(o_tap_state) == 4'h0
        || $past(fall) && $past(o_tap_state) inside {4'h8, 4'hF}) else $error("latch moved");
    op_run_a: assert property (!$past(i_reset) |-> o_op_run ==
        ($past(o_tap_state) == 4'h1 && $past(o_instruction) == bstap_pkg::OPC_RUN_TEST))
        else $error("operation outside idle");
endmodule
bind bstap_controller bstap_monitor mon (.i_clk, .i_reset, .i_tck, .i_tms, .i_tdi,
    .i_boundary_capture, .o_tdo, .o_tdo_oe, .o_test_mode, .o_op_run, .o_control, .o_boundary,
    .o_instruction, .o_tap_state);
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the scan controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic i_clk, i_reset, i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe, o_test_mode, o_op_run;
    logic [35:0] i_boundary_capture, o_boundary, got;
    logic [10:0] o_control;
    logic [7:0] o_instruction;
    logic [3:0] o_tap_state;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    bstap_controller dut (.i_clk, .i_reset, .i_tck, .i_tms, .i_tdi, .i_boundary_capture, .o_tdo,
        .o_tdo_oe, .o_test_mode, .o_op_run, .o_control, .o_boundary, .o_instruction, .o_tap_state);
    bstap_master m (.i_tdo(o_tdo), .i_tdo_oe(o_tdo_oe), .o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi));
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 8000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Scan clock periods with mode and data bits taken LSB first
    task automatic steps(input int n, input logic [35:0] tms_b, input logic [35:0] tdi_b,
        output logic [35:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++)
            m.step(tms_b[i], tdi_b[i], dout[i]);
    endtask
    // Full scan from idle back to idle
    task automatic shot(input logic ir, input int n, input logic [35:0] din,
        output logic [35:0] dout);
        logic [35:0] tail;
        steps(ir ? 4 : 3, ir ? 36'h3 : 36'h1, '1, tail);
        steps(n, 36'h1 << (n - 1), din, dout);
        steps(2, 36'h1, '1, tail);
        chk("tdo z", tail[0], 1'bz);
    endtask
    task automatic t_reset_state();
        chk("state", o_tap_state, 4'h0);
        chk("ir", o_instruction, bstap_pkg::IR_RESET_VALUE);
        chk("bnd", o_boundary, bstap_pkg::BOUNDARY_RESET_VALUE);
        chk("ctl", o_control, bstap_pkg::CONTROL_RESET_VALUE);
        chk("mode", o_test_mode, 1'b0);
        steps(6, 36'h1F, '1, got);
        chk("idle", o_tap_state, 4'h1);
    endtask
    task automatic t_boundary();
        shot(1'b1, 8, bstap_pkg::OPC_BOUNDARY, got);
        chk("ir cap", got, bstap_pkg::IR_CAPTURE_VALUE);
        chk("ir", o_instruction, bstap_pkg::OPC_BOUNDARY);
        chk("mode", o_test_mode, 1'b1);
        shot(1'b0, 36, 36'h3_1234_5678, got);
        chk("bnd cap", got, 36'hA_5C3F_0912);
        chk("bnd", o_boundary, 36'h3_1234_5678);
    endtask
    task automatic t_pause();
        logic [35:0] lo;
        logic [35:0] hi;
        steps(3, 36'h1, '1, got);
        steps(20, 36'h8_0000, 36'hF_0F0F_0F0F, lo);
        @(posedge i_clk) i_boundary_capture <= 36'h0;
        steps(7, 36'h20, '1, got);
        steps(16, 36'h8000, 36'hF0F0, hi);
        steps(2, 36'h1, '1, got);
        chk("paused", {hi[15:0], lo[19:0]}, 36'hA_5C3F_0912);
        chk("bnd", o_boundary, 36'hF_0F0F_0F0F);
    endtask
    task automatic t_control_bypass();
        shot(1'b1, 8, bstap_pkg::OPC_CONTROL, got);
        shot(1'b0, 11, 36'h5A3, got);
        chk("ctl cap", got, bstap_pkg::CONTROL_RESET_VALUE);
        chk("ctl", o_control, 11'h5A3);
        shot(1'b1, 8, 8'h55, got);
        shot(1'b0, 4, 36'hB, got);
        chk("bypass", got, 36'h6);
        chk("bnd", o_boundary, 36'hF_0F0F_0F0F);
    endtask
    task automatic t_run_escape();
        shot(1'b1, 8, bstap_pkg::OPC_RUN_TEST, got);
        chk("run", o_op_run, 1'b1);
        steps(1, 36'h1, '1, got);
        chk("run", o_op_run, 1'b0);
        steps(7, 36'h7C, '1, got);
        chk("state", o_tap_state, 4'h0);
    endtask
    initial begin
        i_reset = 1'b1;
        i_boundary_capture = 36'hA_5C3F_0912;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (3) @(posedge i_clk);
        t_reset_state();
        t_boundary();
        t_pause();
        t_control_bypass();
        t_run_escape();
        t_reset_state();
        give_verdict();
    end
endmodule
`default_nettype wire
